// ---- bench/tb.sv ----
`timescale 1ns/1ps
module tb import ufmc_pkg::*; ;
    logic        clock = 1'b0, reset = 1'b1, hwrite = 1'b0, lb = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, x;
    logic        hreadyout, hresp, txp, rtsn, ga, gb, rxp, ctsn;
    logic [15:0] rnd = 16'd9622, w1, w2;
    int          fails = 0, compares = 0, cyc = 0, lbad = 0, t1, t2, nb, gap;
    always #5 clock = ~clock;
    ufmc_top u_dut (.CLOCK(clock), .RESET(reset), .HSEL(1'b1), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout),
        .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .SERIAL_RECEIVE_PIN(rxp),
        .CLEAR_TO_SEND_PIN_N(ctsn), .SERIAL_TRANSMIT_PIN(txp), .REQUEST_TO_SEND_PIN_N(rtsn),
        .GENERAL_OUTPUT_A(ga), .GENERAL_OUTPUT_B(gb));
    ufmc_remote u_far (.clock(clock), .txd(txp), .rxd(rxp), .cts_n(ctsn));
    // ------------------------------------------------------------
    // bus master, checks and closing
    // ------------------------------------------------------------
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        htrans <= 2'h2;
        hwrite <= wr;
        haddr  <= {24'h0, a};
        do @(posedge clock); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clock); while (hreadyout !== 1'b1);
        x = hrdata;
    endtask : bus
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(x, e);
        chk({31'h0, hresp}, 32'h0);
    endtask : rdchk
    // waits for holding slot (m=1) or whole transmitter (m=3) to empty
    task automatic drain(input logic [1:0] m);
        repeat (2) @(posedge clock);
        do bus(1'b0, STAT_OFF, 32'h0); while ((x[1:0] & m) != 2'h0);
    endtask : drain
    task automatic test_done();
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : test_done
    // random source for data bytes and parity faults
    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : lfsr
    // expected wire frame: data, parity, first stop
    function automatic logic [15:0] frame(input logic [7:0] d, input logic [5:0] f,
                                          input logic flip);
        int n, ones;
        n = 5 + f[1:0];
        ones = 0;
        for (int i = 0; i < n; i++) ones += d[i];
        frame = 16'(d & ((1 << n) - 1));
        if (f[3]) frame[n] = (f[5] ? !f[4] : (ones + !f[4]) % 2) ^ flip;
        frame[n + f[3]] = 1'b1;
    endfunction : frame
    // timeout, and the loopback watch on the transmit pin
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (lb && txp !== 1'b1) lbad <= lbad + 1;
        if (cyc == 90000) begin
            fails++;
            test_done();
        end
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (3) @(posedge clock);
        reset <= 1'b0;
        rdchk(LFC_OFF, 32'h3);
        rdchk(MLC_OFF, 32'h0);
        bus(1'b1, MLC_OFF, 32'h0d);
        rdchk(MLC_OFF, 32'h0c);
        chk({gb, ga}, 32'h3);
        bus(1'b1, MLC_OFF, 32'h0);
        bus(1'b1, DIV_OFF, 32'h0);
        // the divider only reloads at zero, so let the old count run out
        repeat (64) @(posedge clock);
        // every format code; second character proves the stop length
        for (int f = 0; f < 64; f++) begin
            rnd = lfsr(rnd);
            nb = 6 + f[1:0] + f[3];
            gap = nb * 16 + (f[2] ? ((f[1:0] == 2'h0) ? 24 : 32) : 16);
            bus(1'b1, LFC_OFF, 32'(f));
            fork
                begin
                    bus(1'b1, TXD_OFF, {24'h0, rnd[7:0]});
                    drain(2'h1);
                    bus(1'b1, TXD_OFF, {24'h0, ~rnd[7:0]});
                end
                begin
                    u_far.grab(nb, w1, t1);
                    u_far.grab(nb, w2, t2);
                end
            join
            chk(w1, frame(rnd[7:0], f, 1'b0));
            chk(w2, frame(~rnd[7:0], f, 1'b0));
            chk(32'(t2 - t1 >= gap && t2 - t1 <= gap + 3), 32'h1);
            u_far.send(nb, frame(rnd[7:0], f, rnd[8]));
            rdchk(RXD_OFF, 32'(frame(rnd[7:0], f, 1'b0) & ((16'h1 << (5 + f[1:0])) - 1))
                  | 32'h100 | (32'(f[3] & rnd[8]) << 9));
        end
        // loopback with a stuck-low receive pin
        bus(1'b1, LFC_OFF, 32'h3);
        bus(1'b1, MLC_OFF, 32'h10);
        lb <= 1'b1;
        u_far.rxd <= 1'b0;
        bus(1'b1, TXD_OFF, 32'ha5);
        drain(2'h3);
        lb <= 1'b0;
        u_far.rxd <= 1'b1;
        chk(32'(lbad), 32'h0);
        rdchk(RXD_OFF, 32'h1a5);
        // autoflow, clear-to-send only: start held off until granted
        bus(1'b1, MLC_OFF, 32'h20);
        u_far.cts_n <= 1'b1;
        bus(1'b1, TXD_OFF, 32'h3c);
        repeat (300) @(posedge clock);
        rdchk(STAT_OFF, 32'hd);
        fork
            u_far.grab(9, w1, t1);
            u_far.cts_n <= 1'b0;
        join
        chk(w1, 16'h13c);
        // autoflow with request automation: pin follows a waiting byte
        bus(1'b1, MLC_OFF, 32'h22);
        repeat (2) @(posedge clock);
        chk(rtsn, 1'b0);
        u_far.send(9, 16'h15a);
        chk(rtsn, 1'b1);
        rdchk(RXD_OFF, 32'h15a);
        repeat (2) @(posedge clock);
        chk(rtsn, 1'b0);
        // no autoflow: a denied clear-to-send changes nothing
        bus(1'b1, MLC_OFF, 32'h2);
        u_far.cts_n <= 1'b1;
        fork
            u_far.grab(9, w1, t1);
            bus(1'b1, TXD_OFF, 32'h81);
        join
        chk(w1, 16'h181);
        chk(rtsn, 1'b0);
        test_done();
    end
endmodule : tb

// ---- bench/ufmc_remote.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------
// far-end serial port; one bit is 16 clocks with divisor 0
// ----------------------------------------------------------------
module ufmc_remote (
    // clock
    input  wire logic clock,
    // serial and flow pins
    input  wire logic txd,
    output logic      rxd,
    output logic      cts_n
);
    int cyc = 0;
    // line idles high as on a pulled-up wire; clear-to-send granted
    initial begin
        rxd   = 1'b1;
        cts_n = 1'b0;
    end
    // free cycle count, stamps frame starts
    always @(posedge clock) cyc <= cyc + 1;
    // catch n bits after the start bit, lsb first, mid-bit
    task automatic grab(input int n, output logic [15:0] w, output int t0);
        w = 16'h0;
        for (int k = 0; k < 5000 && txd !== 1'b0; k++) @(posedge clock);
        t0 = cyc;
        repeat (8) @(posedge clock);
        for (int i = 0; i < n; i++) begin
            repeat (16) @(posedge clock);
            w[i] = txd;
        end
    endtask : grab
    // start bit, then n bits of w lsb first (w carries its own stop)
    task automatic send(input int n, input logic [15:0] w);
        for (int i = -1; i < n; i++) begin
            rxd <= (i < 0) ? 1'b0 : w[i];
            repeat (16) @(posedge clock);
        end
        rxd <= 1'b1;
    endtask : send
endmodule : ufmc_remote

// ---- src/ufmc_pkg.sv ----
// ----------------------------------------------------------------------------
// shared constants, types and functions of the serial port
// ----------------------------------------------------------------------------
package ufmc_pkg;

    // register byte offsets on the bus
    localparam logic [7:0]  LFC_OFF    = 8'h00;   // line_format_control
    localparam logic [7:0]  MLC_OFF    = 8'h04;   // modem_line_control
    localparam logic [7:0]  TXD_OFF    = 8'h08;   // transmit holding word
    localparam logic [7:0]  RXD_OFF    = 8'h0c;   // receive word with flags
    localparam logic [7:0]  DIV_OFF    = 8'h10;   // baud divisor
    localparam logic [7:0]  STAT_OFF   = 8'h14;   // transfer and pin status

    // line_format_control fields
    localparam int          LFC_WLS    = 0;       // word_length_select, 2 bits
    localparam int          LFC_STB    = 2;       // stop_count_select
    localparam int          LFC_PEN    = 3;       // parity_enable
    localparam int          LFC_EPS    = 4;       // even_parity_select
    localparam int          LFC_STICK  = 5;       // stick_parity_select
    localparam logic [5:0]  LFC_RESET  = 6'h03;

    // modem_line_control fields
    localparam int          MLC_RTS    = 1;
    localparam int          MLC_OUTA   = 2;       // general_output_a
    localparam int          MLC_OUTB   = 3;       // general_output_b
    localparam int          MLC_LOOP   = 4;
    localparam int          MLC_AFE    = 5;       // autoflow_enable
    localparam logic [5:0]  MLC_WMASK  = 6'h3e;   // bit 0 is reserved, reads 0
    localparam logic [5:0]  MLC_RESET  = 6'h00;

    // baud timing, in ticks of the sixteen-times clock
    localparam logic [15:0] DIV_RESET  = 16'h0035;
    localparam logic [5:0]  BIT_LAST   = 6'h0f;   // sixteen ticks per bit
    localparam logic [3:0]  MID_TICK   = 4'h7;    // start bit checked mid-bit
    localparam logic [5:0]  STOP_ONE   = 6'h10;   // 16 ticks
    localparam logic [5:0]  STOP_HALF  = 6'h18;   // 24 ticks
    localparam logic [5:0]  STOP_TWO   = 6'h20;   // 32 ticks

    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} ufmc_tx_e;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} ufmc_rx_e;

    // data bits per character
    function automatic logic [3:0] ufmc_nbits(input logic [1:0] word_length_select);
        return 4'h5 + {2'h0, word_length_select};
    endfunction : ufmc_nbits

    // transmitted stop length in ticks
    function automatic logic [5:0] ufmc_stop_ticks(input logic stb, input logic [1:0] word_length_select);
        if (!stb) begin
            return STOP_ONE;
        end
        return (word_length_select == 2'h0) ? STOP_HALF : STOP_TWO;
    endfunction : ufmc_stop_ticks

    // parity bit value; bits above the word length never count
    function automatic logic ufmc_parity(input logic [7:0] d, input logic [1:0] word_length_select,
                                         input logic even_parity_select, input logic stick);
        logic [7:0] mask;
        mask = 8'hff >> (2'h3 - word_length_select);
        if (stick) begin
            return ~even_parity_select;
        end
        return (^(d & mask)) ^ ~even_parity_select;
    endfunction : ufmc_parity

endpackage : ufmc_pkg

// ---- src/ufmc_rx.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// receive shifter
// ----------------------------------------------------------------------------
module ufmc_rx import ufmc_pkg::*; (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       reset,
    // baud tick, frame format, line
    input  wire logic       tick,
    input  wire logic [5:0] cfg,
    input  wire logic       rxd,
    // received character
    output logic            done,
    output logic [7:0]      data,
    output logic            perr,
    output logic            ferr
);

    typedef struct packed {
        ufmc_rx_e   state;
        logic [3:0] cnt;
        logic [2:0] idx;
        logic [7:0] sh;
        logic       perr;
        logic       ferr;
        logic       done;
    } ufmc_rx_s;

    ufmc_rx_s s_r;
    ufmc_rx_s s_nxt;

    // bits sampled mid-cell: start checked at tick 7, later bits sixteen ticks apart
    always_comb begin
        s_nxt      = s_r;
        s_nxt.done = 1'b0;
        if (tick) begin
            s_nxt.cnt = s_r.cnt + 4'h1;
            case (s_r.state)
                RX_IDLE: begin
                    s_nxt.cnt = 4'h0;
                    if (!rxd) begin
                        s_nxt.state = RX_START;
                    end
                end
                RX_START: if (s_r.cnt == MID_TICK) begin
                    // a short low pulse is taken as noise
                    s_nxt.state = rxd ? RX_IDLE : RX_DATA;
                    s_nxt.cnt   = 4'h0;
                    s_nxt.idx   = 3'h0;
                    s_nxt.sh    = 8'h00;
                    s_nxt.perr  = 1'b0;
                end
                RX_DATA: if (s_r.cnt == 4'hf) begin
                    s_nxt.sh[s_r.idx] = rxd;
                    if ({1'b0, s_r.idx} == ufmc_nbits(cfg[LFC_WLS +: 2]) - 4'h1) begin
                        s_nxt.state = cfg[LFC_PEN] ? RX_PAR : RX_STOP;
                    end else begin
                        s_nxt.idx = s_r.idx + 3'h1;
                    end
                end
                RX_PAR: if (s_r.cnt == 4'hf) begin
                    s_nxt.perr  = (rxd != ufmc_parity(s_r.sh, cfg[LFC_WLS +: 2], cfg[LFC_EPS],
                                                      cfg[LFC_STICK]));
                    s_nxt.state = RX_STOP;
                end
                RX_STOP: if (s_r.cnt == 4'hf) begin
                    // only the first stop bit is looked at
                    s_nxt.ferr  = !rxd;
                    s_nxt.done  = 1'b1;
                    s_nxt.state = RX_IDLE;
                end
                default: s_nxt.state = RX_IDLE;
            endcase
        end
    end

    // state register
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            s_r <= '{state: RX_IDLE, default: '0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign done = s_r.done;
    assign data = s_r.sh;
    assign perr = s_r.perr;
    assign ferr = s_r.ferr;

    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    a_no_perr: assert property ((done && !cfg[LFC_PEN] && !$past(cfg[LFC_PEN], 2)) |-> !perr)
        else $error("parity error without parity");
    a_first_stop: assert property (done |-> (s_r.state == RX_IDLE) ##1 !done)
        else $error("receiver waited past first stop bit");

endmodule : ufmc_rx

// ---- src/ufmc_top.sv ----
// Implementation choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
// What this block does
// - parity disabled: no parity bit sent or checked, stick and even ignored
// - parity on, stick off, even 0: odd parity generated and checked
// - parity on, stick off, even 1: even parity generated and checked
// - parity on, stick on, even 0: parity bit always one
// - parity on, stick on, even 1: parity bit always zero
// - stop length 16 ticks, or 24 for five bits, else 32 when selected
// - word length code 0 to 3 gives 5 to 8 data bits
// - parity bit sits after last data bit, before first stop bit
// - autoflow off means no hardware request/clear handshake
// - autoflow on: clear line gates each launch; request line handshakes with the remote port only when request bit is 1
// - autoflow on, request bit 0: clear-to-send flow control only
// - autoflow on, request bit 1: request output and clear input both automatic
// - loopback off: pins connect to transmitter and receiver
// - loopback on: transmit pin held high
// - loopback on: receive pin ignored
// - loopback on: transmit shifter output feeds the receive shifter
module ufmc_top import ufmc_pkg::*; (
    // clock and reset
    input  wire logic        CLOCK,
    input  wire logic        RESET,
    // ahb-lite slave
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic [31:0]      HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    // serial line and modem pins
    input  wire logic        SERIAL_RECEIVE_PIN,
    input  wire logic        CLEAR_TO_SEND_PIN_N,
    output logic             SERIAL_TRANSMIT_PIN,
    output logic             REQUEST_TO_SEND_PIN_N,
    // general purpose outputs
    output logic             GENERAL_OUTPUT_A,
    output logic             GENERAL_OUTPUT_B
);

    // ------------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [5:0]  lfc;         // line_format_control
        logic [5:0]  mlc;         // modem_line_control
        logic [15:0] div;
        logic [15:0] bcnt;
        logic        tick;
        logic [7:0]  hold;
        logic        hold_v;
        logic [7:0]  rxbuf;
        logic        rx_v;
        logic        rx_perr;
        logic        rx_ferr;
        logic        rx_ovr;
        logic        rx_s1;
        logic        rx_s2;
        logic        cts_s1;
        logic        cts_s2;
        logic        txd_pin;
        logic        rts_n;
        logic        ap_v;
        logic        ap_w;
        logic [7:0]  ap_addr;
        logic [31:0] hrdata;
    } ufmc_top_s;

    ufmc_top_s s_r;
    ufmc_top_s s_nxt;

    logic       tx_busy;
    logic       tx_line;
    logic       tx_start;
    logic       cts_ok;
    logic       rx_in;
    logic       rx_done;
    logic [7:0] rx_data;
    logic       rx_perr;
    logic       rx_ferr;

    // ------------------------------------------------------------------------
    // flow control and loopback routing
    // ------------------------------------------------------------------------

    // clear-to-send gates only the launch, a running character always finishes
    assign cts_ok   = !s_r.mlc[MLC_AFE] || !s_r.cts_s2;
    assign tx_start = s_r.hold_v && !tx_busy && cts_ok;
    // receiver hears its own transmitter in loopback, the pin otherwise
    assign rx_in    = s_r.mlc[MLC_LOOP] ? tx_line : s_r.rx_s2;

    // ------------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;

        // two-stage synchronisers for the asynchronous pins
        s_nxt.rx_s1  = SERIAL_RECEIVE_PIN;
        s_nxt.rx_s2  = s_r.rx_s1;
        s_nxt.cts_s1 = CLEAR_TO_SEND_PIN_N;
        s_nxt.cts_s2 = s_r.cts_s1;

        // sixteen-times baud tick, one cycle every div+1 clocks
        if (s_r.bcnt == 16'h0000) begin
            s_nxt.bcnt = s_r.div;
            s_nxt.tick = 1'b1;
        end else begin
            s_nxt.bcnt = s_r.bcnt - 16'h0001;
            s_nxt.tick = 1'b0;
        end

        // write data phase; a transmit word while the holding slot is full is dropped
        if (s_r.ap_v && s_r.ap_w) begin
            case (s_r.ap_addr)
                LFC_OFF:  s_nxt.lfc = HWDATA[5:0];
                MLC_OFF:  s_nxt.mlc = HWDATA[5:0] & MLC_WMASK;
                TXD_OFF:  if (!s_r.hold_v) begin
                    s_nxt.hold   = HWDATA[7:0];
                    s_nxt.hold_v = 1'b1;
                end
                DIV_OFF:  s_nxt.div = HWDATA[15:0];
                default:  ;
            endcase
        end

        // launch empties the holding slot; never collides with a write above
        if (tx_start) begin
            s_nxt.hold_v = 1'b0;
        end

        // address phase; read data taken now so that it leaves a flip-flop
        s_nxt.ap_v    = HSEL && HTRANS[1] && HREADY;
        s_nxt.ap_w    = HWRITE;
        s_nxt.ap_addr = HADDR[7:0];
        if (s_nxt.ap_v && !HWRITE) begin
            case (HADDR[7:0])
                LFC_OFF:  s_nxt.hrdata = {26'h0, s_nxt.lfc};
                MLC_OFF:  s_nxt.hrdata = {26'h0, s_nxt.mlc};
                DIV_OFF:  s_nxt.hrdata = {16'h0, s_nxt.div};
                RXD_OFF:  s_nxt.hrdata = {20'h0, s_r.rx_ovr, s_r.rx_ferr, s_r.rx_perr,
                                          s_r.rx_v, s_r.rxbuf};
                STAT_OFF: s_nxt.hrdata = {28'h0, s_r.rts_n, s_r.cts_s2, tx_busy, s_r.hold_v};
                default:  s_nxt.hrdata = 32'h0000_0000;
            endcase
            // reading the receive word releases it together with its flags
            if (HADDR[7:0] == RXD_OFF) begin
                s_nxt.rx_v    = 1'b0;
                s_nxt.rx_perr = 1'b0;
                s_nxt.rx_ferr = 1'b0;
                s_nxt.rx_ovr  = 1'b0;
            end
        end

        // a new character wins over a clear in the same cycle
        if (rx_done) begin
            if (s_nxt.rx_v) begin
                s_nxt.rx_ovr = 1'b1;
            end
            s_nxt.rxbuf   = rx_data;
            s_nxt.rx_v    = 1'b1;
            s_nxt.rx_perr = rx_perr;
            s_nxt.rx_ferr = rx_ferr;
        end

        // pins: idle-high transmit in loopback, request follows buffer room when automatic
        s_nxt.txd_pin = s_nxt.mlc[MLC_LOOP] ? 1'b1 : tx_line;
        if (s_nxt.mlc[MLC_AFE] && s_nxt.mlc[MLC_RTS]) begin
            s_nxt.rts_n = s_nxt.rx_v;
        end else begin
            s_nxt.rts_n = !s_nxt.mlc[MLC_RTS];
        end
    end

    // ------------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------------
    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            s_r <= '{lfc: LFC_RESET, mlc: MLC_RESET, div: DIV_RESET, rx_s1: 1'b1,
                     rx_s2: 1'b1, cts_s1: 1'b1, cts_s2: 1'b1, txd_pin: 1'b1,
                     rts_n: 1'b1, default: '0};
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // shifters
    // ------------------------------------------------------------------------
    ufmc_tx u_tx (
        .clock (CLOCK),
        .reset (RESET),
        .tick  (s_r.tick),
        .cfg   (s_r.lfc),
        .start (tx_start),
        .data  (s_r.hold),
        .busy  (tx_busy),
        .txd   (tx_line)
    );

    ufmc_rx u_rx (
        .clock (CLOCK),
        .reset (RESET),
        .tick  (s_r.tick),
        .cfg   (s_r.lfc),
        .rxd   (rx_in),
        .done  (rx_done),
        .data  (rx_data),
        .perr  (rx_perr),
        .ferr  (rx_ferr)
    );

    // ------------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------------
    // zero-wait slave, every transfer answered okay
    assign HRDATA                = s_r.hrdata;
    assign HREADYOUT             = 1'b1;
    assign HRESP                 = 1'b0;
    assign SERIAL_TRANSMIT_PIN   = s_r.txd_pin;
    assign REQUEST_TO_SEND_PIN_N = s_r.rts_n;
    assign GENERAL_OUTPUT_A      = s_r.mlc[MLC_OUTA];
    assign GENERAL_OUTPUT_B      = s_r.mlc[MLC_OUTB];

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RESET);

    a_loop_txd_high: assert property (s_r.mlc[MLC_LOOP] |-> SERIAL_TRANSMIT_PIN)
        else $error("transmit pin not high in loopback");
    a_loop_rx_route: assert property ((s_r.mlc[MLC_LOOP] && !tx_line) |-> !rx_in)
        else $error("loopback not routed to receiver");
    a_rts_auto: assert property ((s_r.mlc[MLC_AFE] && s_r.mlc[MLC_RTS]) |->
        (REQUEST_TO_SEND_PIN_N == s_r.rx_v))
        else $error("automatic request output wrong");
    a_rts_manual: assert property ((s_r.mlc[MLC_AFE] && !s_r.mlc[MLC_RTS]) |->
        REQUEST_TO_SEND_PIN_N)
        else $error("request output driven without automation");
    a_cts_hold: assert property ((s_r.mlc[MLC_AFE] && s_r.cts_s2 && !tx_busy) |=> !tx_busy)
        else $error("character started with clear-to-send off");
    a_no_flow: assert property ((!s_r.mlc[MLC_AFE] && s_r.hold_v && !tx_busy) |=>
        (tx_busy && !s_r.hold_v))
        else $error("launch held back without autoflow");
    a_gpo_write: assert property ((s_r.ap_v && s_r.ap_w && s_r.ap_addr == MLC_OFF) |=>
        (GENERAL_OUTPUT_A == $past(HWDATA[2]) && GENERAL_OUTPUT_B == $past(HWDATA[3])))
        else $error("general outputs not stored");

endmodule : ufmc_top

// ---- src/ufmc_tx.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// transmit shifter
// ----------------------------------------------------------------------------
module ufmc_tx import ufmc_pkg::*; (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       reset,
    // baud tick and frame format
    input  wire logic       tick,
    input  wire logic [5:0] cfg,
    // character request
    input  wire logic       start,
    input  wire logic [7:0] data,
    // shifter state and line
    output logic            busy,
    output logic            txd
);

    typedef struct packed {
        ufmc_tx_e   state;
        logic [5:0] cfg;
        logic [5:0] cnt;
        logic [2:0] idx;
        logic [7:0] sh;
        logic       txd;
        logic [5:0] stop_seen;
    } ufmc_tx_s;

    ufmc_tx_s s_r;
    ufmc_tx_s s_nxt;

    // format is frozen at the start so a mid-character write cannot tear it
    always_comb begin
        s_nxt = s_r;
        if (s_r.state == TX_IDLE) begin
            s_nxt.stop_seen = 6'h00;
            if (start) begin
                s_nxt.state = TX_START;
                s_nxt.cfg   = cfg;
                s_nxt.sh    = data;
                s_nxt.cnt   = 6'h00;
            end
        end else if (tick) begin
            s_nxt.cnt = s_r.cnt + 6'h01;
            case (s_r.state)
                TX_START: if (s_r.cnt == BIT_LAST) begin
                    s_nxt.cnt   = 6'h00;
                    s_nxt.idx   = 3'h0;
                    s_nxt.state = TX_DATA;
                end
                TX_DATA: if (s_r.cnt == BIT_LAST) begin
                    s_nxt.cnt = 6'h00;
                    if ({1'b0, s_r.idx} == ufmc_nbits(s_r.cfg[LFC_WLS +: 2]) - 4'h1) begin
                        s_nxt.state = s_r.cfg[LFC_PEN] ? TX_PAR : TX_STOP;
                    end else begin
                        s_nxt.idx = s_r.idx + 3'h1;
                    end
                end
                TX_PAR: if (s_r.cnt == BIT_LAST) begin
                    s_nxt.cnt   = 6'h00;
                    s_nxt.state = TX_STOP;
                end
                TX_STOP: begin
                    s_nxt.stop_seen = s_r.stop_seen + 6'h01;
                    if (s_r.cnt == ufmc_stop_ticks(s_r.cfg[LFC_STB], s_r.cfg[LFC_WLS +: 2])
                                   - 6'h01) begin
                        s_nxt.state = TX_IDLE;
                    end
                end
                default: s_nxt.state = TX_IDLE;
            endcase
        end
        // line level follows the state being entered
        case (s_nxt.state)
            TX_START: s_nxt.txd = 1'b0;
            TX_DATA:  s_nxt.txd = s_nxt.sh[s_nxt.idx];
            TX_PAR:   s_nxt.txd = ufmc_parity(s_nxt.sh, s_nxt.cfg[LFC_WLS +: 2],
                                              s_nxt.cfg[LFC_EPS], s_nxt.cfg[LFC_STICK]);
            default:  s_nxt.txd = 1'b1;
        endcase
    end

    // state register
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            s_r <= '{state: TX_IDLE, txd: 1'b1, default: '0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign busy = (s_r.state != TX_IDLE);
    assign txd  = s_r.txd;

    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    a_stop_len: assert property ((s_r.state == TX_STOP && s_nxt.state == TX_IDLE) |->
        (s_nxt.stop_seen == (!s_r.cfg[LFC_STB] ? 6'd16 : (s_r.cfg[1:0] == 2'h0 ? 6'd24 : 6'd32))))
        else $error("stop bit length wrong");
    a_no_parity: assert property (!s_r.cfg[LFC_PEN] |-> s_r.state != TX_PAR)
        else $error("parity sent while disabled");
    a_parity_val: assert property ((s_r.state == TX_PAR) |-> txd == (s_r.cfg[5] ? !s_r.cfg[4]
        : ((^(s_r.sh & (8'hff >> (2'h3 - s_r.cfg[1:0])))) ^ !s_r.cfg[4])))
        else $error("parity bit value wrong");
    a_word_len: assert property ((s_r.state == TX_DATA && s_nxt.state != TX_DATA) |->
        s_r.idx == 3'(s_r.cfg[1:0]) + 3'h4)
        else $error("data bit count wrong");

endmodule : ufmc_tx
